// *** radio_spi_config_port.sv ***
// Serial configuration port: header decode, register file, TX and RX buffers.
// Assumes serial clock and select come from the master; radio core signals are on clk.
// Overview of operation
// - Slave port with data in, data out, serial clock and active-low select.
// - All bytes shift most significant bit first in both directions.
// - Each transaction opens with a header: direction, burst, six-bit address.
// - Select rising mid-transfer cancels it and drops the partial byte.
// - Data out goes low only once regulator and oscillator are stable.
// - Outside sleep and crystal-off, data out goes low three clk cycles after select falls.
// - Port reaches configuration registers and separate 64-byte RX and TX buffers.
// - Status byte shifts out while each header or write data byte arrives; read data bytes shift out read data.
// - Status bit 7 is active-low ready, high until supply and crystal settle.
// - Status bits 6:4 give main state: idle, receive, transmit, synth ready.
// - Status bits 3:0 give RX bytes available or TX bytes free, saturating 15.
`timescale 1ns/10ps
module radio_spi_config_port
  import spi_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic osc_stable_n,
  input wire logic crystal_off_state,
  input wire spi_cfg_pkg::radio_state_t radio_state,
  input wire logic rx_push_valid,
  input wire logic [7:0] rx_push_data,
  output logic rx_push_ready,
  output logic tx_pop_valid,
  output logic [7:0] tx_pop_data,
  input wire logic tx_pop_ready,
  output logic [7:0] cfg_data,
  output logic [5:0] cfg_addr,
  output logic cfg_wr
);
  import spi_cfg_pkg::*;

  spi_xfer_if xf ();
  logic miso_bit;

  spi_link_shifter u_shift (
    .sclk(sclk),
    .chip_select_low(chip_select_low),
    .mosi(mosi),
    .miso_bit(miso_bit),
    .xf(xf)
  );

  // Level and toggle synchronisers into clk
  logic [2:0] hdr_s_q;
  logic [2:0] byte_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] rdy_s_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hdr_s_q <= 3'h0;
      byte_s_q <= 3'h0;
      cs_s_q <= 2'h3;
      rdy_s_q <= 2'h3;
    end else begin
      hdr_s_q <= {hdr_s_q[1:0], xf.hdr_tgl};
      byte_s_q <= {byte_s_q[1:0], xf.byte_tgl};
      cs_s_q <= {cs_s_q[0], chip_select_low};
      rdy_s_q <= {rdy_s_q[0], osc_stable_n};
    end
  end
  wire hdr_ev = hdr_s_q[2] ^ hdr_s_q[1];
  wire byte_ev = byte_s_q[2] ^ byte_s_q[1];

  // Header fields
  logic read_q;
  logic burst_q;
  logic [5:0] addr_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_q <= 1'b0;
      burst_q <= 1'b0;
      addr_q <= 6'h00;
    end else if (cs_s_q[1]) begin
      burst_q <= 1'b0;
    end else if (hdr_ev) begin
      read_q <= xf.header[BIT_RW];
      burst_q <= xf.header[BIT_BURST];
      addr_q <= xf.header[5:0];
    end else if (byte_ev && burst_q && addr_q != ADDR_FIFO) begin
      addr_q <= addr_q + 6'h01;
    end
  end

  // Configuration register file
  logic [7:0] cfg_mem [0:47];
  logic [7:0] cfg_rd;
  wire is_fifo = addr_q == ADDR_FIFO;
  wire is_reg = addr_q <= ADDR_REG_LAST;
  wire wr_ev = byte_ev && !read_q;
  always_ff @(posedge clk) begin
    if (wr_ev && is_reg) begin
      cfg_mem[addr_q] <= xf.rx_byte;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_data <= CFG_RESET;
      cfg_addr <= 6'h00;
      cfg_wr <= 1'b0;
    end else begin
      cfg_wr <= wr_ev && is_reg;
      if (wr_ev && is_reg) begin
        cfg_data <= xf.rx_byte;
        cfg_addr <= addr_q;
      end
    end
  end

  // TX buffer, 64 bytes: port writes, radio drains
  logic [7:0] txm [0:63];
  logic [5:0] tx_wp_q;
  logic [5:0] tx_rp_q;
  logic [6:0] tx_cnt_q;
  wire tx_push = wr_ev && is_fifo && tx_cnt_q != 7'(FIFO_DEPTH);
  wire tx_pop = tx_pop_valid && tx_pop_ready;
  always_ff @(posedge clk) begin
    if (tx_push) begin
      txm[tx_wp_q] <= xf.rx_byte;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_wp_q <= 6'h00;
      tx_rp_q <= 6'h00;
      tx_cnt_q <= CNT_RESET;
      tx_pop_valid <= 1'b0;
      tx_pop_data <= 8'h00;
    end else begin
      if (tx_push) begin
        tx_wp_q <= tx_wp_q + 6'h01;
      end
      if (tx_pop || !tx_pop_valid) begin
        tx_pop_valid <= tx_cnt_q != CNT_RESET;
        tx_pop_data <= txm[tx_rp_q];
        if (tx_cnt_q != CNT_RESET) begin
          tx_rp_q <= tx_rp_q + 6'h01;
        end
      end
      tx_cnt_q <= tx_cnt_q + 7'(tx_push)
        - 7'((tx_pop || !tx_pop_valid) && tx_cnt_q != CNT_RESET);
    end
  end

  // RX buffer, 64 bytes: radio fills, port reads; a full buffer stalls the radio
  logic [7:0] rxm [0:63];
  logic [5:0] rx_wp_q;
  logic [5:0] rx_rp_q;
  logic [6:0] rx_cnt_q;
  wire rx_push = rx_push_valid && rx_push_ready;
  wire rx_pop = (hdr_ev ? xf.header[BIT_RW] && xf.header[5:0] == ADDR_FIFO
                        : byte_ev && read_q && is_fifo) && rx_cnt_q != CNT_RESET;
  logic [7:0] rd_q;
  always_ff @(posedge clk) begin
    if (rx_push) begin
      rxm[rx_wp_q] <= rx_push_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_wp_q <= 6'h00;
      rx_rp_q <= 6'h00;
      rx_cnt_q <= CNT_RESET;
      rx_push_ready <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_wp_q <= rx_wp_q + 6'h01;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 6'h01;
      end
      rx_cnt_q <= rx_cnt_q + 7'(rx_push) - 7'(rx_pop);
      rx_push_ready <= (rx_cnt_q + 7'(rx_push) - 7'(rx_pop)) < 7'(FIFO_DEPTH);
    end
  end

  // Read data staged for the next byte out; a read header prefetches
  logic [5:0] nxt_addr;
  always_comb begin
    // FIFO address never advances in a burst
    nxt_addr = hdr_ev ? xf.header[5:0] : (burst_q && !is_fifo ? addr_q + 6'h01 : addr_q);
    cfg_rd = (nxt_addr <= ADDR_REG_LAST) ? cfg_mem[nxt_addr] : 8'h00;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_q <= 8'h00;
    end else if (hdr_ev || byte_ev) begin
      rd_q <= (nxt_addr == ADDR_FIFO) ? rxm[rx_rp_q]
                                      : cfg_rd;
      if (hdr_ev && xf.header[5:0] == ADDR_FIFO) begin
        rd_q <= rxm[rx_rp_q];
      end
    end
  end
  assign xf.tx_byte = rd_q;

  // Status byte
  logic [7:0] stat_q;
  logic [6:0] tx_free;
  logic [6:0] fill;
  always_comb begin
    tx_free = 7'(FIFO_DEPTH) - tx_cnt_q;
    fill = read_q ? rx_cnt_q : tx_free;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat_q <= 8'h80;
    end else begin
      stat_q[STAT_RDY] <= rdy_s_q[1];
      stat_q[STAT_STATE_HI:STAT_STATE_LO] <= radio_state;
      stat_q[3:0] <= (fill > CNT_SAT) ? STAT_SAT : fill[3:0];
    end
  end
  assign xf.status = stat_q;

  // Data out pin: ready bit held until oscillator stable; released while deselected
  always_ff @(posedge clk) begin
    if (!nrst) begin
      miso_o <= 1'b1;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= cs_s_q[1];
      // Ready rides on status bit 7; crystal off holds the pin high
      miso_o <= crystal_off_state ? 1'b1 : miso_bit;
    end
  end
endmodule

// *** spi_cfg_pkg.sv ***
// Constants shared by the serial configuration port and its link-side shifter.
// Assumes a 40 MHz system clock and a master-driven serial clock.
package spi_cfg_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_DEPTH = 64;
  localparam int unsigned CNT_W = 7;
  localparam int unsigned BIT_RW = 7;
  localparam int unsigned BIT_BURST = 6;
  localparam int unsigned STAT_RDY = 7;
  localparam int unsigned STAT_STATE_HI = 6;
  localparam int unsigned STAT_STATE_LO = 4;
  localparam logic [3:0] STAT_SAT = 4'hf;
  localparam logic [6:0] CNT_SAT = 7'h0f;
  localparam logic [5:0] ADDR_FIFO = 6'h3f;
  localparam logic [5:0] ADDR_REG_LAST = 6'h2f;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [6:0] CNT_RESET = 7'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  typedef enum logic [2:0] {
    radio_idle = 3'b000,
    radio_rx = 3'b001,
    radio_tx = 3'b010,
    synth_on_tx_ready = 3'b011
  } radio_state_t;
endpackage

// *** spi_xfer_if.sv ***
// Carrier between the link-side shifter and the system-side port logic.
// Toggles cross from the serial clock domain; data is held stable meanwhile.
`timescale 1ns/10ps
interface spi_xfer_if;
  logic hdr_tgl;
  logic byte_tgl;
  logic [7:0] rx_byte;
  logic [7:0] header;
  logic [7:0] status;
  logic [7:0] tx_byte;
  modport link (output hdr_tgl, output byte_tgl, output rx_byte, output header,
                input status, input tx_byte);
  modport core (input hdr_tgl, input byte_tgl, input rx_byte, input header,
                output status, output tx_byte);
endinterface

// *** spi_link_shifter.sv ***
// Serial-clock-domain shifter: samples data in on rising edge, drives out on falling edge.
// Assumes status and tx_byte from the core are stable across each byte.
`timescale 1ns/10ps
module spi_link_shifter
  import spi_cfg_pkg::*;
(
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic mosi,
  output logic miso_bit,
  spi_xfer_if.link xf
);
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic first_q;
  logic [7:0] out_byte;
  logic [2:0] out_idx;
  // No reset in this domain; both toggles start level with their synchronisers
  logic hdr_tgl_q = 1'b0;
  logic byte_tgl_q = 1'b0;
  logic [7:0] rx_q;
  logic [7:0] hdr_q;
  logic [2:0] obit_q;

  // Frame reset by select: a partial byte never reaches the core
  always_ff @(posedge sclk or posedge chip_select_low) begin
    if (chip_select_low) begin
      bit_q <= BIT_FIRST;
      sh_q <= 7'h00;
      first_q <= 1'b1;
    end else begin
      sh_q <= {sh_q[5:0], mosi};
      bit_q <= bit_q + 3'h1;
      if (bit_q == BIT_LAST) begin
        first_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (!chip_select_low && bit_q == BIT_LAST) begin
      rx_q <= {sh_q, mosi};
      if (first_q) begin
        hdr_q <= {sh_q, mosi};
        hdr_tgl_q <= ~hdr_tgl_q;
      end else begin
        byte_tgl_q <= ~byte_tgl_q;
      end
    end
  end

  // Output shifts on falling edge; status during header and writes, read data after
  always_ff @(negedge sclk or posedge chip_select_low) begin
    if (chip_select_low) begin
      obit_q <= 3'h1;
    end else begin
      obit_q <= bit_q + 3'h1;
    end
  end

  always_comb begin
    out_byte = (first_q || !hdr_q[BIT_RW]) ? xf.status : xf.tx_byte;
    out_idx = (chip_select_low || bit_q == 3'h0) ? 3'h0 : obit_q - 3'h1;
    miso_bit = out_byte[3'h7 - out_idx];
  end

  assign xf.hdr_tgl = hdr_tgl_q;
  assign xf.byte_tgl = byte_tgl_q;
  assign xf.rx_byte = rx_q;
  assign xf.header = hdr_q;
endmodule

// *** spi_port_chk.sv ***
// Assertions on the serial port's top-level pins.
// Assumes binding onto radio_spi_config_port by port name.
`timescale 1ns/10ps
module spi_port_chk
  import spi_cfg_pkg::*;
(
  input logic clk,
  input logic nrst,
  input logic chip_select_low,
  input logic miso_o,
  input logic miso_oe_n,
  input logic osc_stable_n,
  input logic crystal_off_state,
  input logic tx_pop_valid,
  input logic [7:0] tx_pop_data,
  input logic tx_pop_ready,
  input logic [5:0] cfg_addr,
  input logic cfg_wr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wr_pulse_a: assert property (cfg_wr |=> !cfg_wr) else $error("cfg_wr too long");
  sel_on_a: assert property ($fell(chip_select_low) |-> ##[1:4] !miso_oe_n)
    else $error("miso not enabled");
  sel_off_a: assert property ($rose(chip_select_low) |-> ##[1:4] miso_oe_n)
    else $error("miso not released");
  not_ready_a: assert property (osc_stable_n [*5] ##0 !miso_oe_n |-> miso_o)
    else $error("miso low before ready");
  ready_low_a: assert property ($fell(chip_select_low) && !osc_stable_n
    && !crystal_off_state |-> ##[1:8] !miso_o) else $error("ready bit late");
  tx_hold_a: assert property (tx_pop_valid && !tx_pop_ready
    |=> tx_pop_valid && $stable(tx_pop_data)) else $error("tx word lost");
  addr_map_a: assert property (cfg_wr |-> cfg_addr <= ADDR_REG_LAST)
    else $error("cfg write off map");
  addr_hold_a: assert property ($changed(cfg_addr) |-> cfg_wr || $past(cfg_wr))
    else $error("cfg_addr moved");
endmodule

// *** spi_host_model.sv ***
// Host master model for the link pins.
// Released miso reads as the inverse of its last driven level.
`timescale 1ns/10ps
module spi_host_model (
  output logic sclk,
  output logic chip_select_low,
  output logic mosi,
  input logic miso_o,
  input logic miso_oe_n
);
  logic last;
  logic so;
  assign so = miso_oe_n ? ~last : miso_o;
  always @(miso_o or miso_oe_n) if (!miso_oe_n) last = miso_o;
  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    mosi = 1'b0;
  end
  task automatic open_frame(input int lim, output logic ok);
    chip_select_low = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      #25;
      ok = (so === 1'b0);
    end
  endtask
  // 64 ns clock; the pause after each byte covers the port's read prefetch
  task automatic shift(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosi = d[i];
      #32;
      q[i] = so;
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
    end
    #160;
  endtask
  task automatic close_frame();
    #100;
    chip_select_low = 1'b1;
    mosi = ~mosi;
    #300;
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the serial configuration port.
// Host model drives the link pins; the radio side is driven here.
`timescale 1ns/10ps
module tb_top;
  import spi_cfg_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, chip_select_low, mosi, miso_o, miso_oe_n, ok, r;
  logic osc_stable_n = 1'b0;
  logic crystal_off_state = 1'b0;
  radio_state_t radio_state = radio_idle;
  logic rx_push_valid = 1'b0;
  logic tx_pop_ready = 1'b0;
  logic rx_push_ready, tx_pop_valid, cfg_wr;
  logic [7:0] rx_push_data = 8'h00;
  logic [7:0] tx_pop_data, cfg_data, st, q;
  logic [5:0] cfg_addr;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [13:0] cfg_seen[$];
  logic [7:0] tx_seen[$];
  always #12.5 clk = ~clk;
  spi_host_model spi_host_model_i (.sclk, .chip_select_low, .mosi, .miso_o, .miso_oe_n);
  radio_spi_config_port radio_spi_config_port_i (.clk, .nrst, .sclk, .chip_select_low,
    .mosi, .miso_o, .miso_oe_n, .osc_stable_n, .crystal_off_state, .radio_state,
    .rx_push_valid, .rx_push_data, .rx_push_ready, .tx_pop_valid, .tx_pop_data,
    .tx_pop_ready, .cfg_data, .cfg_addr, .cfg_wr);
  always @(posedge clk) begin
    cycles++;
    if (cfg_wr === 1'b1) cfg_seen.push_back({cfg_addr, cfg_data});
    if (tx_pop_valid === 1'b1 && tx_pop_ready) tx_seen.push_back(tx_pop_data);
    if (cycles == 30000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hdr(input logic [7:0] h);
    spi_host_model_i.open_frame(12, ok);
    chk("ready", ok, 1'b1);
    spi_host_model_i.shift(h, 8, st);
  endtask
  task automatic s_ready();
    @(negedge clk);
    osc_stable_n = 1'b1;
    repeat (6) @(negedge clk);
    spi_host_model_i.open_frame(10, ok);
    chk("early", ok, 1'b0);
    chk("hold", miso_o, 1'b1);
    @(negedge clk);
    osc_stable_n = 1'b0;
    crystal_off_state = 1'b1;
    spi_host_model_i.open_frame(10, ok);
    chk("crystal_off_state", ok, 1'b0);
    @(negedge clk);
    crystal_off_state = 1'b0;
    spi_host_model_i.open_frame(20, ok);
    chk("late", ok, 1'b1);
    spi_host_model_i.close_frame();
  endtask
  task automatic s_cfg();
    hdr(8'h05);
    spi_host_model_i.shift(8'ha5, 8, q);
    chk("wstat", q, {1'b0, radio_idle, 4'hf});
    spi_host_model_i.close_frame();
    hdr(8'h50);
    chk("status", st, {1'b0, radio_idle, 4'hf});
    spi_host_model_i.shift(8'h11, 8, q);
    spi_host_model_i.shift(8'h22, 8, q);
    spi_host_model_i.close_frame();
    chk("cfg0", cfg_seen.pop_front(), {6'h05, 8'ha5});
    chk("cfg1", cfg_seen.pop_front(), {6'h10, 8'h11});
    chk("cfg2", cfg_seen.pop_front(), {6'h11, 8'h22});
    hdr(8'h85);
    spi_host_model_i.shift(8'h00, 8, q);
    spi_host_model_i.close_frame();
    chk("rd5", q, 8'ha5);
    hdr(8'hd0);
    spi_host_model_i.shift(8'h00, 8, q);
    chk("rd10", q, 8'h11);
    spi_host_model_i.shift(8'h00, 8, q);
    spi_host_model_i.close_frame();
    chk("rd11", q, 8'h22);
  endtask
  task automatic s_abort();
    hdr(8'h07);
    spi_host_model_i.shift(8'hff, 4, q);
    spi_host_model_i.close_frame();
    hdr(8'h08);
    spi_host_model_i.shift(8'h5a, 8, q);
    spi_host_model_i.close_frame();
    chk("abort", cfg_seen.pop_front(), {6'h08, 8'h5a});
  endtask
  task automatic s_states();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      radio_state = radio_state_t'(i);
      hdr(8'h80);
      spi_host_model_i.close_frame();
      chk("state", st[6:4], i[2:0]);
    end
  endtask
  task automatic s_tx();
    hdr(8'h7f);
    spi_host_model_i.shift(8'h3c, 8, q);
    spi_host_model_i.shift(8'hc3, 8, q);
    spi_host_model_i.close_frame();
    chk("stall", {tx_pop_valid, 4'(tx_seen.size())}, 5'h10);
    @(negedge clk);
    tx_pop_ready = 1'b1;
    repeat (20) @(negedge clk);
    chk("tx0", tx_seen.pop_front(), 8'h3c);
    chk("tx1", tx_seen.pop_front(), 8'hc3);
  endtask
  task automatic s_rx();
    int n;
    n = 0;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      r = rx_push_ready;
      rx_push_valid = 1'b1;
      rx_push_data = n[7:0];
      @(posedge clk);
      if (r) n++;
    end
    @(negedge clk);
    rx_push_valid = 1'b0;
    chk("fill", 14'(n), 14'h40);
    hdr(8'hff);
    for (int k = 0; k < n; k++) begin
      spi_host_model_i.shift(8'h00, 8, q);
      chk("rx", q, k[7:0]);
    end
    spi_host_model_i.close_frame();
    hdr(8'hff);
    spi_host_model_i.close_frame();
    chk("empty", st[3:0], 4'h0);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    s_ready();
    s_cfg();
    s_abort();
    s_states();
    s_tx();
    s_rx();
    wrap_up();
  end
endmodule
bind radio_spi_config_port spi_port_chk spi_port_chk_i (.clk, .nrst, .chip_select_low,
  .miso_o, .miso_oe_n, .osc_stable_n, .crystal_off_state, .tx_pop_valid, .tx_pop_data,
  .tx_pop_ready, .cfg_addr, .cfg_wr);
